//--- core_state_pkg.sv
// Summary of operation
// - arithmetic unit finishes a register or immediate operation in one clock cycle.
// - two operands read, operation done and result written back in one cycle.
// - thirty-two 8-bit registers, cleared to zero on reset.
// - port schemes 8 to 8, 8+8 to 8, 8+8 to 16, 16 to 16.
// - flags updated with result conditions after every arithmetic or logic operation.
// - flag bit 7 is global interrupt enable; clear blocks every interrupt.
// - enable cleared on interrupt entry, set on return; set and clear commands too.
// - bit 6 is the transfer store, loaded from and copied to register bits.
// - bit 5 records carry out of the low nibble for add, subtract and negate operations.
// - bit 4 equals negative flag xor overflow flag after every arithmetic or logic operation.
// - bit 3 flags two's complement overflow of an arithmetic result.
// - bit 2 set when the result is negative, cleared otherwise.
// - bit 1 set when the result is zero, cleared otherwise.
// - bit 0 records the carry of the operation.
// - top six registers form three 16-bit pointers, even low byte, odd high.
// - pointers support displacement, post-increment and pre-decrement adjustment.
// - stack pointer addresses the top of a downward-growing stack.
// - byte push decrements pointer by 1, byte pop increments it by 1.
// - call or interrupt entry decrements by 2, returns increment by 2.
// - pointer bytes at I/O 0x3e high and 0x3d low, read/write, reset to last address.
// - core runs on the undivided clock, all state updated on its rising edge.
package core_state_pkg;
  localparam int unsigned num_regs = 32;
  localparam logic [7:0] flag_reset = 8'h00;
  localparam int unsigned bit_irq_en = 7;
  localparam int unsigned bit_tstore = 6;
  localparam int unsigned bit_half = 5;
  localparam int unsigned bit_sign = 4;
  localparam int unsigned bit_ovf = 3;
  localparam int unsigned bit_neg = 2;
  localparam int unsigned bit_zero = 1;
  localparam int unsigned bit_carry = 0;
  localparam logic [5:0] io_stack_ptr_low = 6'h3d;
  localparam logic [5:0] io_stack_ptr_high = 6'h3e;
  localparam logic [5:0] io_flags = 6'h3f;
  localparam logic [4:0] ptr_x_low = 5'h1a;
  localparam logic [4:0] ptr_y_low = 5'h1c;
  localparam logic [4:0] ptr_z_low = 5'h1e;
  typedef enum logic [3:0] {
    op_none, op_add, op_adc, op_sub, op_sbc, op_and, op_or, op_xor,
    op_com, op_neg, op_inc, op_dec, op_lsr, op_ror, op_asr, op_mov
  } alu_op_t;
  typedef enum logic [2:0] {
    wb_none, wb_alu8, wb_word16, wb_ptr_adj, wb_tstore_to_bit
  } wb_kind_t;
  typedef enum logic [2:0] {
    sp_hold, sp_push1, sp_pop1, sp_push2, sp_pop2
  } sp_op_t;
  typedef enum logic [1:0] {
    adj_none, adj_disp, adj_post_inc, adj_pre_dec
  } ptr_mode_t;
endpackage

//--- cpu_flags_regfile_stack.sv
`timescale 1ns/1ps
module cpu_flags_regfile_stack #(
  parameter logic [15:0] last_sram_address = 16'h08ff
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] rd_addr,
  input wire logic [4:0] rr_addr,
  input wire logic [7:0] immediate,
  input wire logic use_immediate,
  input wire core_state_pkg::alu_op_t alu_op,
  input wire core_state_pkg::wb_kind_t wb_kind,
  input wire logic [15:0] word_result,
  input wire logic [1:0] ptr_sel,
  input wire core_state_pkg::ptr_mode_t ptr_mode,
  input wire logic [5:0] ptr_disp,
  input wire logic [2:0] bit_sel,
  input wire logic bit_to_transfer_store,
  input wire logic set_irq_enable,
  input wire logic clear_irq_enable,
  input wire logic irq_taken,
  input wire logic return_from_irq,
  input wire core_state_pkg::sp_op_t sp_op,
  input wire logic [5:0] io_addr,
  input wire logic io_write,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic [7:0] operand_d,
  output logic [7:0] operand_r,
  output logic [15:0] operand_word,
  output logic [7:0] alu_result,
  output logic [15:0] ptr_address,
  output logic [15:0] stack_ptr,
  output logic [7:0] cpu_condition_flags,
  output logic irq_allowed
);
  import core_state_pkg::*;

  logic [7:0] regs [num_regs];
  logic [7:0] stack_ptr_low_byte;
  logic [7:0] stack_ptr_high_byte;
  logic [7:0] next_flags;
  logic [15:0] next_sp;

  ////////////////////////////////////////////////////////////////////////////
  // operand read, combinational so the whole op fits one cycle
  wire [7:0] rd_val = regs[rd_addr];
  wire [7:0] rr_val = use_immediate ? immediate : regs[rr_addr];
  // an immediate stands in for the second register only, never the first
  wire [4:0] rd_pair = {rd_addr[4:1], 1'b0};
  wire [4:0] rd_pair_hi = rd_pair | 5'h01;
  wire [15:0] pair_val = {regs[rd_pair_hi], regs[rd_pair]};
  assign operand_d = rd_val;
  assign operand_r = rr_val;
  assign operand_word = pair_val;

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic unit
  wire c_in = cpu_condition_flags[bit_carry];
  wire use_cin = (alu_op == op_adc) || (alu_op == op_sbc);
  wire cin_eff = use_cin & c_in;
  wire [8:0] sum9 = {1'b0, rd_val} + {1'b0, rr_val} + {8'h00, cin_eff};
  wire [8:0] dif9 = {1'b0, rd_val} - {1'b0, rr_val} - {8'h00, cin_eff};
  wire [4:0] sum_lo = {1'b0, rd_val[3:0]} + {1'b0, rr_val[3:0]} + {4'h0, cin_eff};
  wire [4:0] dif_lo = {1'b0, rd_val[3:0]} - {1'b0, rr_val[3:0]} - {4'h0, cin_eff};
  wire [7:0] neg_val = 8'h00 - rd_val;
  // one named result per family; the case below only selects
  wire [7:0] and_val = rd_val & rr_val;
  wire [7:0] or_val = rd_val | rr_val;
  wire [7:0] xor_val = rd_val ^ rr_val;
  wire [7:0] com_val = ~rd_val;
  wire [7:0] inc_val = rd_val + 8'h01;
  wire [7:0] dec_val = rd_val - 8'h01;
  wire is_ror = (alu_op == op_ror);
  wire is_asr = (alu_op == op_asr);
  // rotate feeds the old carry in, arithmetic shift keeps the sign
  wire shift_in = is_ror ? c_in : (is_asr ? rd_val[7] : 1'b0);
  wire [7:0] shift_val = {shift_in, rd_val[7:1]};
  wire shift_c = rd_val[0];
  // overflow from operand signs, so a carry out never fakes it
  wire add_v = (rd_val[7] == rr_val[7]) && (sum9[7] != rd_val[7]);
  wire sub_v = (rd_val[7] != rr_val[7]) && (dif9[7] != rd_val[7]);
  wire add_c = sum9[8];
  wire sub_c = dif9[8];
  wire add_h = sum_lo[4];
  wire sub_h = dif_lo[4];
  wire neg_c = (neg_val != 8'h00);
  wire neg_h = neg_val[3] | rd_val[3];
  wire neg_v = (neg_val == 8'h80);
  wire inc_v = (rd_val == 8'h7f);
  wire dec_v = (rd_val == 8'h80);
  wire shift_v = shift_in ^ shift_c;
  logic [7:0] res;
  logic c_out, v_out, h_out, h_def, arith;
  always_comb begin
    res = rd_val;
    c_out = c_in;
    v_out = 1'b0;
    h_out = cpu_condition_flags[bit_half];
    h_def = 1'b0;
    arith = 1'b1;
    case (alu_op)
      op_add, op_adc: begin
        res = sum9[7:0];
        c_out = add_c;
        h_out = add_h;
        h_def = 1'b1;
        v_out = add_v;
      end
      op_sub, op_sbc: begin
        res = dif9[7:0];
        c_out = sub_c;
        h_out = sub_h;
        h_def = 1'b1;
        v_out = sub_v;
      end
      op_and: res = and_val;
      op_or: res = or_val;
      op_xor: res = xor_val;
      op_com: begin
        res = com_val;
        c_out = 1'b1;
      end
      op_neg: begin
        res = neg_val;
        c_out = neg_c;
        h_out = neg_h;
        h_def = 1'b1;
        v_out = neg_v;
      end
      op_inc: begin
        res = inc_val;
        v_out = inc_v;
      end
      op_dec: begin
        res = dec_val;
        v_out = dec_v;
      end
      op_lsr, op_ror, op_asr: begin
        res = shift_val;
        c_out = shift_c;
        v_out = shift_v;
      end
      op_mov: begin
        res = rr_val;
        arith = 1'b0;
      end
      default: arith = 1'b0;
    endcase
  end
  assign alu_result = res;

  ////////////////////////////////////////////////////////////////////////////
  // pointer pairs among the top six registers
  wire sel_x = (ptr_sel == 2'd0);
  wire sel_y = (ptr_sel == 2'd1);
  // codes 2 and 3 both pick the last pair, so no select is left dangling
  wire [4:0] ptr_low_idx = sel_x ? ptr_x_low : (sel_y ? ptr_y_low : ptr_z_low);
  wire [4:0] ptr_high_idx = ptr_low_idx | 5'h01;
  wire [15:0] ptr_raw = {regs[ptr_high_idx], regs[ptr_low_idx]};
  wire [15:0] ptr_dec = ptr_raw - 16'h0001;
  wire [15:0] ptr_inc = ptr_raw + 16'h0001;
  wire [15:0] ptr_disp_addr = ptr_raw + {10'h000, ptr_disp};
  wire is_disp = (ptr_mode == adj_disp);
  wire is_post_inc = (ptr_mode == adj_post_inc);
  wire is_pre_dec = (ptr_mode == adj_pre_dec);
  assign ptr_address = is_disp ? ptr_disp_addr : (is_pre_dec ? ptr_dec : ptr_raw);
  // displacement only offsets the address; the pair keeps its value
  wire [15:0] ptr_new = is_post_inc ? ptr_inc : (is_pre_dec ? ptr_dec : ptr_raw);

  ////////////////////////////////////////////////////////////////////////////
  // register file write, one port scheme per cycle
  wire [7:0] bit_mask = 8'h01 << bit_sel;
  wire t_bit = cpu_condition_flags[bit_tstore];
  wire [7:0] bld_val = t_bit ? (rd_val | bit_mask) : (rd_val & ~bit_mask);
  wire wr_alu = (wb_kind == wb_alu8) && (alu_op != op_none);
  wire wr_word = (wb_kind == wb_word16);
  wire wr_ptr = (wb_kind == wb_ptr_adj);
  wire wr_bld = (wb_kind == wb_tstore_to_bit);
  genvar gi;
  generate
    for (gi = 0; gi < num_regs; gi++) begin : g_reg
      localparam logic [4:0] idx = 5'(gi);
      wire hit_d = (rd_addr == idx);
      wire hit_wlo = wr_word && (rd_pair == idx);
      wire hit_whi = wr_word && (rd_pair_hi == idx);
      wire hit_plo = wr_ptr && (ptr_low_idx == idx);
      wire hit_phi = wr_ptr && (ptr_high_idx == idx);
      wire hit_alu = hit_d && wr_alu;
      wire hit_bld = hit_d && wr_bld;
      // cleared on reset so no read ever returns an unknown
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          regs[gi] <= 8'h00;
        end else if (hit_alu) begin
          regs[gi] <= res;
        end else if (hit_bld) begin
          regs[gi] <= bld_val;
        end else if (hit_wlo) begin
          regs[gi] <= word_result[7:0];
        end else if (hit_whi) begin
          regs[gi] <= word_result[15:8];
        end else if (hit_plo) begin
          regs[gi] <= ptr_new[7:0];
        end else if (hit_phi) begin
          regs[gi] <= ptr_new[15:8];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // flags; the handler keeps its own copy, nothing is saved here
  wire sel_flags = (io_addr == io_flags);
  wire sel_spl = (io_addr == io_stack_ptr_low);
  wire sel_sph = (io_addr == io_stack_ptr_high);
  wire io_wr_flags = io_write && sel_flags;
  wire io_wr_spl = io_write && sel_spl;
  wire io_wr_sph = io_write && sel_sph;
  wire upd = (alu_op != op_none) && arith;
  wire [7:0] flags_base = io_wr_flags ? io_wdata : cpu_condition_flags;
  wire res_zero = (res == 8'h00);
  wire res_neg = res[7];
  wire res_sign = res_neg ^ v_out;
  wire tstore_bit = rd_val[bit_sel];
  wire irq_en_set = set_irq_enable || return_from_irq;
  wire irq_en_clr = clear_irq_enable || irq_taken;
  always_comb begin
    next_flags = flags_base;
    if (upd) begin
      next_flags[bit_carry] = c_out;
      next_flags[bit_zero] = res_zero;
      next_flags[bit_neg] = res_neg;
      next_flags[bit_ovf] = v_out;
      next_flags[bit_sign] = res_sign;
      if (h_def) begin
        next_flags[bit_half] = h_out;
      end
    end
    if (bit_to_transfer_store) begin
      next_flags[bit_tstore] = tstore_bit;
    end
    // entry and clear beat set so a simultaneous interrupt cannot slip in
    if (irq_en_clr) begin
      next_flags[bit_irq_en] = 1'b0;
    end else if (irq_en_set) begin
      next_flags[bit_irq_en] = 1'b1;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_condition_flags <= flag_reset;
    end else begin
      cpu_condition_flags <= next_flags;
    end
  end
  // clear command blocks in the same cycle it is issued
  assign irq_allowed = cpu_condition_flags[bit_irq_en] && !clear_irq_enable;

  ////////////////////////////////////////////////////////////////////////////
  // stack pointer, grows downward
  wire [15:0] sp_cur = {stack_ptr_high_byte, stack_ptr_low_byte};
  // wraps at 16 bits; keeping it inside the SRAM is up to software
  wire [15:0] sp_dec1 = sp_cur - 16'h0001;
  wire [15:0] sp_inc1 = sp_cur + 16'h0001;
  wire [15:0] sp_dec2 = sp_cur - 16'h0002;
  wire [15:0] sp_inc2 = sp_cur + 16'h0002;
  always_comb begin
    next_sp = sp_cur;
    if (io_wr_spl) begin
      next_sp[7:0] = io_wdata;
    end
    if (io_wr_sph) begin
      next_sp[15:8] = io_wdata;
    end
    // a stack op wins over a same-cycle pointer write from software
    case (sp_op)
      sp_push1: next_sp = sp_dec1;
      sp_pop1: next_sp = sp_inc1;
      sp_push2: next_sp = sp_dec2;
      sp_pop2: next_sp = sp_inc2;
      default: ;
    endcase
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stack_ptr_low_byte <= last_sram_address[7:0];
      stack_ptr_high_byte <= last_sram_address[15:8];
    end else begin
      stack_ptr_low_byte <= next_sp[7:0];
      stack_ptr_high_byte <= next_sp[15:8];
    end
  end
  assign stack_ptr = sp_cur;

  ////////////////////////////////////////////////////////////////////////////
  // io read; stack pointer bytes and flags only, other addresses read zero
  assign io_rdata = sel_spl ? stack_ptr_low_byte :
                    sel_sph ? stack_ptr_high_byte :
                    sel_flags ? cpu_condition_flags : 8'h00;
endmodule // cpu_flags_regfile_stack

//--- cpu_flags_regfile_stack_assertions.sv
`timescale 1ns/1ps
module cpu_flags_regfile_stack_assertions
  import core_state_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire core_state_pkg::alu_op_t alu_op,
  input wire core_state_pkg::sp_op_t sp_op,
  input wire logic clear_irq_enable,
  input wire logic irq_taken,
  input wire logic return_from_irq,
  input wire logic [7:0] alu_result,
  input wire logic [15:0] stack_ptr,
  input wire logic [7:0] cpu_condition_flags,
  input wire logic irq_allowed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // move and no-op leave the flags alone
  wire flag_upd = alu_op != op_none && alu_op != op_mov;
  ////////////////////////////////////////////////////////////////
  a_push_one_dec: assert property (sp_op == sp_push1 |=> stack_ptr == $past(stack_ptr) - 16'h0001)
    else $error("push did not lower pointer by one");
  a_pop_one_inc: assert property (sp_op == sp_pop1 |=> stack_ptr == $past(stack_ptr) + 16'h0001)
    else $error("pop did not raise pointer by one");
  a_push_two_dec: assert property (sp_op == sp_push2 |=> stack_ptr == $past(stack_ptr) - 16'h0002)
    else $error("call did not lower pointer by two");
  a_pop_two_inc: assert property (sp_op == sp_pop2 |=> stack_ptr == $past(stack_ptr) + 16'h0002)
    else $error("return did not raise pointer by two");
  a_zero_flag_follows: assert property (flag_upd |=> cpu_condition_flags[1] == ($past(alu_result) == 8'h00))
    else $error("zero flag wrong");
  a_neg_flag_follows: assert property (flag_upd |=> cpu_condition_flags[2] == ($past(alu_result) > 8'h7f))
    else $error("negative flag wrong");
  a_sign_is_xor: assert property (flag_upd |=> cpu_condition_flags[4] == (cpu_condition_flags[2] ^ cpu_condition_flags[3]))
    else $error("sign flag not n xor v");
  a_clear_blocks_irq: assert property (clear_irq_enable |-> !irq_allowed ##1 !cpu_condition_flags[7])
    else $error("clear did not block interrupts");
  a_entry_clears_en: assert property (irq_taken |=> !cpu_condition_flags[7] && !irq_allowed)
    else $error("interrupt entry left enable set");
  a_return_sets_en: assert property (return_from_irq && !irq_taken && !clear_irq_enable |=> cpu_condition_flags[7])
    else $error("return did not set enable");
endmodule // cpu_flags_regfile_stack_assertions
bind cpu_flags_regfile_stack cpu_flags_regfile_stack_assertions u_chk (.*);

//--- cpu_flags_regfile_stack_tb.sv
`timescale 1ns/1ps
module cpu_flags_regfile_stack_tb;
  import core_state_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] rd_addr, rr_addr;
  logic [7:0] immediate, io_wdata, io_rdata, operand_d, operand_r, alu_result, cpu_condition_flags;
  logic use_immediate, bit_to_transfer_store, set_irq_enable, clear_irq_enable;
  logic irq_taken, return_from_irq, io_write, irq_allowed;
  alu_op_t alu_op;
  wb_kind_t wb_kind;
  ptr_mode_t ptr_mode;
  sp_op_t sp_op;
  logic [15:0] word_result, operand_word, ptr_address, stack_ptr;
  logic [1:0] ptr_sel;
  logic [5:0] ptr_disp, io_addr;
  logic [2:0] bit_sel;
  int n_mismatch = 0;
  int tests_run = 0;
  sp_op_t sp_tab[4] = '{sp_push1, sp_push2, sp_pop1, sp_pop2};
  logic [15:0] sp_exp[4] = '{16'h08fe, 16'h08fc, 16'h08fd, 16'h08ff};
  always #50 clk = ~clk;
  cpu_flags_regfile_stack u_dut (.*);
  ////////////////////////////////////////////////////////////////
  task automatic rest;
    rd_addr = 5'h00;
    rr_addr = 5'h00;
    immediate = 8'h00;
    use_immediate = 1'b0;
    alu_op = op_none;
    wb_kind = wb_none;
    word_result = 16'h0000;
    ptr_sel = 2'h0;
    ptr_mode = adj_none;
    ptr_disp = 6'h00;
    bit_sel = 3'h0;
    bit_to_transfer_store = 1'b0;
    set_irq_enable = 1'b0;
    clear_irq_enable = 1'b0;
    irq_taken = 1'b0;
    return_from_irq = 1'b0;
    sp_op = sp_hold;
    io_addr = 6'h00;
    io_write = 1'b0;
    io_wdata = 8'h00;
  endtask
  // inputs change at the falling edge or 1 ns after it, away from sampling
  task automatic tick;
    @(negedge clk);
    rest;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [4:0] r, input logic [15:0] w);
    rd_addr = r;
    wb_kind = wb_word16;
    word_result = w;
    tick;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    n_mismatch++;
    stop_test;
  end
  initial begin
    rest;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    chk(stack_ptr, 16'h08ff);
    chk(16'(cpu_condition_flags), 16'h0000);
    put(5'h00, 16'h017f);
    rr_addr = 5'h01;
    alu_op = op_add;
    wb_kind = wb_alu8;
    #1 chk(16'(alu_result), 16'h0080);
    chk(16'(operand_r), 16'h0001);
    tick;
    chk(16'(operand_d), 16'h0080);
    chk(16'(cpu_condition_flags), 16'h002c);
    put(5'h02, 16'h00ff);
    rd_addr = 5'h02;
    use_immediate = 1'b1;
    immediate = 8'h01;
    alu_op = op_add;
    wb_kind = wb_alu8;
    tick;
    chk(16'(cpu_condition_flags), 16'h0023);
    // carry of a logic op is left open, so it is masked
    use_immediate = 1'b1;
    immediate = 8'h80;
    alu_op = op_and;
    tick;
    chk(16'(cpu_condition_flags & 8'h1e), 16'h0014);
    bit_sel = 3'h7;
    bit_to_transfer_store = 1'b1;
    tick;
    rd_addr = 5'h02;
    bit_sel = 3'h4;
    wb_kind = wb_tstore_to_bit;
    tick;
    rd_addr = 5'h02;
    #1 chk(16'(operand_d), 16'h0010);
    set_irq_enable = 1'b1;
    tick;
    chk(16'(irq_allowed), 16'h0001);
    irq_taken = 1'b1;
    tick;
    chk(16'(cpu_condition_flags & 8'hc0), 16'h0040);
    return_from_irq = 1'b1;
    tick;
    chk(16'(irq_allowed), 16'h0001);
    clear_irq_enable = 1'b1;
    #1 chk(16'(irq_allowed), 16'h0000);
    tick;
    foreach (sp_tab[i]) begin
      sp_op = sp_tab[i];
      tick;
      chk(stack_ptr, sp_exp[i]);
    end
    io_write = 1'b1;
    io_addr = io_stack_ptr_low;
    io_wdata = 8'h40;
    tick;
    io_write = 1'b1;
    io_addr = io_stack_ptr_high;
    io_wdata = 8'h01;
    tick;
    io_write = 1'b1;
    io_addr = 6'h20;
    io_wdata = 8'h55;
    #1 chk(16'(io_rdata), 16'h0000);
    tick;
    chk(stack_ptr, 16'h0140);
    // stack operation outranks a same-cycle pointer write
    io_write = 1'b1;
    io_addr = io_stack_ptr_low;
    io_wdata = 8'h99;
    sp_op = sp_push1;
    tick;
    io_addr = io_stack_ptr_low;
    #1 chk(16'(io_rdata), 16'h003f);
    put(5'h1a, 16'h0010);
    ptr_mode = adj_post_inc;
    wb_kind = wb_ptr_adj;
    #1 chk(ptr_address, 16'h0010);
    tick;
    rd_addr = 5'h1a;
    #1 chk(16'(operand_d), 16'h0011);
    put(5'h1c, 16'h2301);
    ptr_sel = 2'h1;
    ptr_mode = adj_pre_dec;
    wb_kind = wb_ptr_adj;
    #1 chk(ptr_address, 16'h2300);
    tick;
    rd_addr = 5'h1c;
    #1 chk(16'(operand_d), 16'h0000);
    put(5'h1e, 16'h0100);
    ptr_sel = 2'h2;
    ptr_mode = adj_disp;
    ptr_disp = 6'h3f;
    #1 chk(ptr_address, 16'h013f);
    tick;
    rd_addr = 5'h1f;
    #1 chk(16'(operand_d), 16'h0001);
    tick;
    // subtract with borrow out of both nibbles; enable clear, store bit set
    rd_addr = 5'h1e;
    rr_addr = 5'h1f;
    alu_op = op_sub;
    wb_kind = wb_alu8;
    #1 chk(operand_word, 16'h0100);
    chk(16'(operand_r), 16'h0001);
    chk(16'(alu_result), 16'h00ff);
    tick;
    chk(16'(cpu_condition_flags), 16'h0075);
    rd_addr = 5'h1e;
    #1 chk(16'(operand_d), 16'h00ff);
    stop_test;
  end
endmodule // cpu_flags_regfile_stack_tb
